// ===== design/asc_top.sv
// Purpose: sequencer for a 10-bit successive approximation converter
// Assumes: comp_in is settled logic on mclk; triggers are mclk pulses
// Notes:   registers on AHB-Lite, zero wait states, always OKAY
`timescale 1ns/1ps
module asc_top
   import asc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // start triggers
   input  wire logic        cmp_event,
   input  wire logic [3:0]  compare_mode_sel,
   input  wire logic        charge_time_event,
   output logic             timer_clr,
   // analog side
   input  wire logic        comp_in,
   input  wire logic        rc_clk,
   output asc_afe_s         afe,
   // port pins
   input  wire logic [11:0] port_pin,
   // status
   output logic             conv_done_irq_flag
);

   typedef struct packed {
      asc_state_e  st;
      logic        converter_on;
      logic        go;
      logic        offset_cal_req;
      logic        trigger_src_sel;
      logic        result_justify;
      logic [3:0]  channel_sel;
      logic [3:0]  pcfg;
      logic [2:0]  acq_time_sel;
      logic [2:0]  conv_clk_sel;
      logic [9:0]  result;
      logic [9:0]  offset;
      logic [9:0]  trial;
      logic [4:0]  cnt;
      logic        tad_rst;
      logic        irq;
      logic        dwr;
      logic [7:0]  daddr;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
      logic        tclr;
      logic [11:0] ps1;
      logic [11:0] ps2;
      logic [11:0] ps3;
      logic [11:0] pstab;
      asc_afe_s    afe;
   } asc_main_s;

   asc_main_s q_ff;
   asc_main_s nxt_q;
   logic      tick;
   logic      run;

   // right: high holds bits 9:8; left: high holds bits 9:2
   function automatic logic [7:0] res_byte(input logic [9:0] r,
                                           input logic       just,
                                           input logic       hi);
      logic [15:0] w;
      w = just ? {6'h00, r} : {r, 6'h00};
      res_byte = hi ? w[15:8] : w[7:0];
   endfunction

   // merge a written byte back into the 10-bit result
   function automatic logic [9:0] put_byte(input logic [9:0] r,
                                           input logic       just,
                                           input logic       hi,
                                           input logic [7:0] d);
      logic [15:0] w;
      w = just ? {6'h00, r} : {r, 6'h00};
      if (hi) begin
         w[15:8] = d;
      end else begin
         w[7:0] = d;
      end
      put_byte = just ? w[9:0] : w[15:6];
   endfunction

   // offset removal floors at zero rather than wrapping
   function automatic logic [9:0] sub_off(input logic [9:0] r,
                                          input logic [9:0] o);
      sub_off = (r > o) ? r - o : 10'h000;
   endfunction

   // channels at or above the boundary are digital
   function automatic logic [11:0] an_mask(input logic [3:0] p);
      logic [11:0] m;
      m = 12'hfff;
      for (int i = 0; i < 12; i++) begin
         if (p > PCFG_ALL_AN && 5'(i) + {1'b0, p} >= NUM_PINS + {1'b0, PCFG_ALL_AN}) begin
            m[i] = 1'b0;
         end
      end
      an_mask = m;
   endfunction

   asc_tad_gen u_tad (
      .mclk    (mclk),
      .resetn  (resetn),
      .run     (run),
      .clk_sel (q_ff.conv_clk_sel),
      .rc_clk  (rc_clk),
      .tick    (tick)
   );

   // an abort drops run for one edge so a wait on the divided clock gets two whole periods
   assign run = ((q_ff.st == ST_ACQ) || (q_ff.st == ST_CONV) ||
                 (q_ff.st == ST_WAIT)) && !q_ff.tad_rst;

   always_comb begin
      logic        acc;
      logic        sw_go;
      logic        sw_clr;
      logic        trig;
      logic        cmp_hit;
      logic [31:0] rd;
      logic [3:0]  b;
      logic [11:0] agree;
      acc     = 1'b0;
      sw_go   = 1'b0;
      sw_clr  = 1'b0;
      trig    = 1'b0;
      cmp_hit = 1'b0;
      rd      = 32'h0000_0000;
      b       = 4'h0;
      agree   = 12'h000;
      nxt_q   = q_ff;

      // pin synchroniser, value moves once stages two and three agree
      nxt_q.ps1   = port_pin;
      nxt_q.ps2   = q_ff.ps1;
      nxt_q.ps3   = q_ff.ps2;
      agree       = ~(q_ff.ps2 ^ q_ff.ps3);
      nxt_q.pstab = (q_ff.pstab & ~agree) | (q_ff.ps3 & agree);

      // bus address phase
      nxt_q.ready = 1'b1;
      nxt_q.resp  = 1'b0;
      acc         = hsel & hready & (htrans == HTRANS_NSEQ);
      nxt_q.dwr   = acc & hwrite;
      nxt_q.daddr = haddr[7:0];
      case (haddr[7:0])
         A_CTRL0: begin
            rd[B0_CAL]      = q_ff.offset_cal_req;
            rd[B0_CHAN+:4]  = q_ff.channel_sel;
            rd[B0_GO]       = q_ff.go;
            rd[B0_ON]       = q_ff.converter_on;
         end
         A_CTRL1: begin
            rd[B1_TSEL]     = q_ff.trigger_src_sel;
            rd[B1_PCFG+:4]  = q_ff.pcfg;
         end
         A_CTRL2: begin
            rd[B2_JUST]     = q_ff.result_justify;
            rd[B2_ACQ+:3]   = q_ff.acq_time_sel;
            rd[B2_CSEL+:3]  = q_ff.conv_clk_sel;
         end
         A_RESH: begin
            rd[7:0] = res_byte(q_ff.result, q_ff.result_justify, 1'b1);
         end
         A_RESL: begin
            rd[7:0] = res_byte(q_ff.result, q_ff.result_justify, 1'b0);
         end
         A_FLAG: begin
            rd[BF_DONE] = q_ff.irq;
         end
         A_PORT: begin
            rd[11:0] = q_ff.pstab & ~an_mask(q_ff.pcfg);
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase
      if (acc && !hwrite) begin
         nxt_q.rdata = rd;
      end

      // bus data phase writes
      if (q_ff.dwr) begin
         case (q_ff.daddr)
            A_CTRL0: begin
               nxt_q.offset_cal_req = hwdata[B0_CAL];
               nxt_q.channel_sel    = hwdata[B0_CHAN+:4];
               nxt_q.converter_on   = hwdata[B0_ON];
               // start only counts once already enabled
               sw_go  = hwdata[B0_GO] & q_ff.converter_on;
               sw_clr = ~hwdata[B0_GO];
            end
            A_CTRL1: begin
               nxt_q.trigger_src_sel = hwdata[B1_TSEL];
               nxt_q.pcfg            = hwdata[B1_PCFG+:4];
            end
            A_CTRL2: begin
               nxt_q.result_justify = hwdata[B2_JUST];
               nxt_q.acq_time_sel   = hwdata[B2_ACQ+:3];
               nxt_q.conv_clk_sel   = hwdata[B2_CSEL+:3];
            end
            A_RESH: begin
               nxt_q.result = put_byte(q_ff.result, q_ff.result_justify, 1'b1,
                                       hwdata[7:0]);
            end
            A_RESL: begin
               nxt_q.result = put_byte(q_ff.result, q_ff.result_justify, 1'b0,
                                       hwdata[7:0]);
            end
            A_FLAG: begin
               if (!hwdata[BF_DONE]) begin
                  nxt_q.irq = 1'b0;
               end
            end
            default: begin
               nxt_q.irq = nxt_q.irq;
            end
         endcase
      end

      // special event trigger
      cmp_hit    = cmp_event & (compare_mode_sel == CMP_TRIG_MODE);
      nxt_q.tclr = cmp_hit;
      trig       = q_ff.trigger_src_sel ? charge_time_event : cmp_hit;
      // a start arriving with a clear wins
      if (sw_go || (trig && q_ff.converter_on)) begin
         nxt_q.go = 1'b1;
      end else if (sw_clr) begin
         nxt_q.go = 1'b0;
      end

      // sequencer; channel and pin direction never steer it
      nxt_q.tad_rst = 1'b0;
      case (q_ff.st)
         ST_OFF: begin
            nxt_q.cnt = 5'h00;
            if (nxt_q.converter_on) begin
               nxt_q.st = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            nxt_q.cnt = 5'h00;
            if (q_ff.go) begin
               if (q_ff.acq_time_sel == 3'h0) begin
                  // caller has already acquired the channel
                  nxt_q.st = ST_DELAY;
               end else begin
                  nxt_q.st = ST_ACQ;
               end
            end
         end
         ST_DELAY: begin
            if (!nxt_q.go) begin
               nxt_q.st  = ST_WAIT;
               nxt_q.cnt = 5'h00;
               nxt_q.tad_rst = 1'b1;
            end else if (q_ff.cnt == {2'h0, INSTR_CLKS} - 5'h01) begin
               nxt_q.st    = ST_CONV;
               nxt_q.cnt   = 5'h00;
               nxt_q.trial = SAR_MSB;
            end else begin
               nxt_q.cnt = q_ff.cnt + 5'h01;
            end
         end
         ST_ACQ: begin
            if (!nxt_q.go) begin
               nxt_q.st  = ST_WAIT;
               nxt_q.cnt = 5'h00;
               nxt_q.tad_rst = 1'b1;
            end else if (tick) begin
               if (q_ff.cnt + 5'h01 == asc_acq_periods(q_ff.acq_time_sel)) begin
                  nxt_q.st    = ST_CONV;
                  nxt_q.cnt   = 5'h00;
                  nxt_q.trial = SAR_MSB;
               end else begin
                  nxt_q.cnt = q_ff.cnt + 5'h01;
               end
            end
         end
         ST_CONV: begin
            if (!nxt_q.go) begin
               // partial result is dropped
               nxt_q.st  = ST_WAIT;
               nxt_q.cnt = 5'h00;
               nxt_q.tad_rst = 1'b1;
            end else if (tick) begin
               if (q_ff.cnt == CONV_PERIODS - 5'h01) begin
                  if (q_ff.offset_cal_req) begin
                     nxt_q.offset         = q_ff.trial;
                     nxt_q.offset_cal_req = 1'b0;
                  end else begin
                     nxt_q.result = sub_off(q_ff.trial, q_ff.offset);
                  end
                  nxt_q.go  = 1'b0;
                  nxt_q.irq = 1'b1;
                  nxt_q.st  = ST_WAIT;
                  nxt_q.cnt = 5'h00;
               end else begin
                  b = 4'h9 - q_ff.cnt[3:0];
                  if (!comp_in) begin
                     nxt_q.trial[b] = 1'b0;
                  end
                  if (b != 4'h0) begin
                     nxt_q.trial[b - 4'h1] = 1'b1;
                  end
                  nxt_q.cnt = q_ff.cnt + 5'h01;
               end
            end
         end
         ST_WAIT: begin
            if (tick && !q_ff.tad_rst) begin
               if (q_ff.cnt + 5'h01 == WAIT_PERIODS) begin
                  nxt_q.st  = ST_SAMPLE;
                  nxt_q.cnt = 5'h00;
               end else begin
                  nxt_q.cnt = q_ff.cnt + 5'h01;
               end
            end
         end
         default: begin
            nxt_q.st = ST_OFF;
         end
      endcase

      // switching off abandons any conversion
      if (!nxt_q.converter_on) begin
         nxt_q.st  = ST_OFF;
         nxt_q.go  = 1'b0;
         nxt_q.cnt = 5'h00;
      end

      // front end: sampling resumes in sample and acquire states
      nxt_q.afe.sample_en = (nxt_q.st == ST_SAMPLE) || (nxt_q.st == ST_ACQ);
      nxt_q.afe.cal_mode  = nxt_q.offset_cal_req && (nxt_q.st == ST_CONV);
      nxt_q.afe.channel   = nxt_q.channel_sel;
      nxt_q.afe.trial     = nxt_q.trial;
   end

   // result survives reset only as a defined zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign hreadyout          = q_ff.ready;
   assign hresp              = q_ff.resp;
   assign hrdata             = q_ff.rdata;
   assign timer_clr          = q_ff.tclr;
   assign afe                = q_ff.afe;
   assign conv_done_irq_flag = q_ff.irq;

endmodule

// ===== design/asc_pkg.sv
// Purpose: shared constants and types for the converter sequencer
// Assumes: mclk is the converter oscillator, 50 MHz
// Notes:   register offsets are byte addresses on the AHB-Lite port
package asc_pkg;

   // register byte offsets
   localparam logic [7:0] A_CTRL0 = 8'h00;
   localparam logic [7:0] A_CTRL1 = 8'h04;
   localparam logic [7:0] A_CTRL2 = 8'h08;
   localparam logic [7:0] A_RESH  = 8'h0c;
   localparam logic [7:0] A_RESL  = 8'h10;
   localparam logic [7:0] A_FLAG  = 8'h14;
   localparam logic [7:0] A_PORT  = 8'h18;

   // field positions
   localparam int B0_CAL  = 7;
   localparam int B0_CHAN = 2;
   localparam int B0_GO   = 1;
   localparam int B0_ON   = 0;
   localparam int B1_TSEL = 7;
   localparam int B1_PCFG = 0;
   localparam int B2_JUST = 7;
   localparam int B2_ACQ  = 3;
   localparam int B2_CSEL = 0;
   localparam int BF_DONE = 0;

   // sequencing constants
   localparam logic [3:0] CMP_TRIG_MODE = 4'hb;
   localparam logic [4:0] CONV_PERIODS  = 5'h0b;
   localparam logic [4:0] WAIT_PERIODS  = 5'h02;
   localparam logic [9:0] SAR_MSB       = 10'h200;
   localparam logic [3:0] PCFG_ALL_AN   = 4'h3;
   localparam logic [4:0] NUM_PINS      = 5'h0c;
   localparam logic [1:0] HTRANS_NSEQ   = 2'h2;
   localparam int         MCLK_NS       = 20;
   localparam int         TCY_NS        = 80;
   localparam logic [2:0] INSTR_CLKS    = 3'((TCY_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [2:0] CSEL_RC       = 3'h3;

   typedef enum logic [2:0] {
      ST_OFF    = 3'h0,
      ST_SAMPLE = 3'h1,
      ST_DELAY  = 3'h2,
      ST_ACQ    = 3'h3,
      ST_CONV   = 3'h4,
      ST_WAIT   = 3'h5
   } asc_state_e;

   // analog front end controls
   typedef struct packed {
      logic       sample_en;
      logic       cal_mode;
      logic [3:0] channel;
      logic [9:0] trial;
   } asc_afe_s;

   // acquisition field to bit periods
   function automatic logic [4:0] asc_acq_periods(input logic [2:0] f);
      case (f)
         3'h1:    asc_acq_periods = 5'h02;
         3'h2:    asc_acq_periods = 5'h04;
         3'h3:    asc_acq_periods = 5'h06;
         3'h4:    asc_acq_periods = 5'h08;
         3'h5:    asc_acq_periods = 5'h0c;
         3'h6:    asc_acq_periods = 5'h10;
         3'h7:    asc_acq_periods = 5'h14;
         default: asc_acq_periods = 5'h00;
      endcase
   endfunction

   // clock select to oscillator divisor
   function automatic logic [6:0] asc_divisor(input logic [2:0] s);
      case (s)
         3'h0:    asc_divisor = 7'h02;
         3'h4:    asc_divisor = 7'h04;
         3'h1:    asc_divisor = 7'h08;
         3'h5:    asc_divisor = 7'h10;
         3'h2:    asc_divisor = 7'h20;
         3'h6:    asc_divisor = 7'h40;
         default: asc_divisor = 7'h02;
      endcase
   endfunction

endpackage

// ===== design/asc_tad_gen.sv
// Purpose: bit period tick from oscillator divide or internal rc clock
// Assumes: rc_clk is asynchronous to mclk and much slower
// Notes:   divider tick phase restarts whenever run drops; rc-clock ticks keep the rc_clk phase
`timescale 1ns/1ps
module asc_tad_gen
   import asc_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // control
   input  wire logic       run,
   input  wire logic [2:0] clk_sel,
   input  wire logic       rc_clk,
   // tick
   output logic            tick
);

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic       lvl;
      logic [6:0] cnt;
      logic       tick;
   } asc_tad_s;

   asc_tad_s q_ff;
   asc_tad_s nxt_q;

   always_comb begin
      nxt_q      = q_ff;
      nxt_q.s1   = rc_clk;
      nxt_q.s2   = q_ff.s1;
      nxt_q.s3   = q_ff.s2;
      nxt_q.tick = 1'b0;
      // first stage stays private to the second
      if (q_ff.s2 == q_ff.s3) begin
         nxt_q.lvl = q_ff.s3;
      end
      if (!run) begin
         nxt_q.cnt = 7'h00;
      end else if (clk_sel[1:0] == CSEL_RC[1:0]) begin
         nxt_q.tick = nxt_q.lvl & ~q_ff.lvl;
      end else if (q_ff.cnt == asc_divisor(clk_sel) - 7'h01) begin
         nxt_q.cnt  = 7'h00;
         nxt_q.tick = 1'b1;
      end else begin
         nxt_q.cnt = q_ff.cnt + 7'h01;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign tick = q_ff.tick;

endmodule

// ===== bench/asc_top_props.sv
// Purpose: port assertions for the converter sequencer
// Assumes: one mclk domain, asynchronous active-low reset
// Notes:   watches only top-level ports
`timescale 1ns/1ps
module asc_top_props
   import asc_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        resetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   // triggers, analog side, status
   input wire logic        cmp_event,
   input wire logic [3:0]  compare_mode_sel,
   input wire logic        timer_clr,
   input wire asc_afe_s    afe,
   input wire logic        conv_done_irq_flag
);
   logic flag_wr_ff;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // address phase of a flag write, so its data phase can be matched
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flag_wr_ff <= 1'b0;
      end else begin
         flag_wr_ff <= hsel && htrans == HTRANS_NSEQ && hwrite && haddr[7:0] == A_FLAG;
      end
   end

   sequence s_trig;
      cmp_event && compare_mode_sel == CMP_TRIG_MODE;
   endsequence
   sequence s_resume;
      !afe.sample_en ##[2:300] afe.sample_en;
   endsequence

   AST_TMR_CLR: assert property (s_trig |=> timer_clr)
      else $error("timer clear missing after trigger");
   AST_TMR_SRC: assert property (timer_clr |-> $past(cmp_event) &&
      $past(compare_mode_sel) == CMP_TRIG_MODE)
      else $error("timer clear without trigger");
   AST_CAL_NO_SAMPLE: assert property (afe.cal_mode |-> !afe.sample_en)
      else $error("input sampled during calibration");
   AST_CAL_END_DONE: assert property ($fell(afe.cal_mode) |-> conv_done_irq_flag)
      else $error("calibration ended without completion");
   AST_CAL_LEN: assert property ($rose(afe.cal_mode) |-> afe.cal_mode[*8])
      else $error("calibration conversion too short");
   AST_RESUME: assert property ($rose(conv_done_irq_flag) |-> s_resume)
      else $error("sampling not resumed after completion");
   AST_CONV_SPAN: assert property ($rose(conv_done_irq_flag) |->
      !$past(afe.sample_en) && !$past(afe.sample_en, 20))
      else $error("completion without full conversion");
   AST_FLAG_CLR: assert property ($fell(conv_done_irq_flag) |->
      $past(flag_wr_ff) && !$past(hwdata[0]))
      else $error("done flag dropped without a clearing write");
endmodule

bind asc_top asc_top_props i_asc_top_props (
   .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .cmp_event(cmp_event),
   .compare_mode_sel(compare_mode_sel), .timer_clr(timer_clr), .afe(afe),
   .conv_done_irq_flag(conv_done_irq_flag));

// ===== bench/tb.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: zero-wait slave; comparator modelled from afe.trial
// Notes:   acq and clock spans compared as differences so fixed lag cancels
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("[ERR] %s exp=%0h got=%0h", nm, exp, got); \
      end \
   end
module tb
   import asc_pkg::*;
;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        cmp_event = 1'b0;
   logic        charge_time_event = 1'b0;
   logic [3:0]  compare_mode_sel = 4'hb;
   logic        rc_clk = 1'b0;
   logic [11:0] port_pin = 12'hb6d;
   logic [9:0]  ain = 10'h2a5;
   logic [9:0]  cal_lvl = 10'h005;
   logic        comp_in;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        timer_clr;
   logic        conv_done_irq_flag;
   asc_afe_s    afe;
   logic [31:0] rd;
   logic        seen;
   int          mismatches = 0;
   int          n_tests = 0;
   int          base;
   int          cyc;
   int          acq_p [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   int          csel [6] = '{0, 4, 1, 5, 2, 6};
   int          dv [6] = '{2, 4, 8, 16, 32, 64};

   always #10 mclk = ~mclk;
   // slow rc source, phase unrelated to mclk
   always #97 rc_clk = ~rc_clk;
   always_comb comp_in = ((afe.cal_mode ? cal_lvl : ain) >= afe.trial);

   asc_top i_asc_top (
      .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_event(cmp_event),
      .compare_mode_sel(compare_mode_sel), .charge_time_event(charge_time_event),
      .timer_clr(timer_clr), .comp_in(comp_in), .rc_clk(rc_clk), .afe(afe),
      .port_pin(port_pin), .conv_done_irq_flag(conv_done_irq_flag));

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NSEQ;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask

   task automatic finish();
      cyc = 0;
      while (conv_done_irq_flag !== 1'b1) begin
         @(posedge mclk);
         cyc++;
      end
      bus(1'b0, A_FLAG, 32'h0);
      `CHK("done flag", 32'h1, rd)
      bus(1'b1, A_FLAG, 32'h0);
      while (afe.sample_en !== 1'b1) @(posedge mclk);
   endtask

   task automatic convert(input logic [7:0] c0);
      bus(1'b1, A_CTRL0, {24'h0, c0});
      finish();
   endtask

   task automatic chk_res(input logic [7:0] hi, input logic [7:0] lo);
      bus(1'b0, A_RESH, 32'h0);
      `CHK("result high", {24'h0, hi}, rd)
      bus(1'b0, A_RESL, 32'h0);
      `CHK("result low", {24'h0, lo}, rd)
   endtask

   task automatic trig(input logic c, input logic t);
      cmp_event <= c;
      charge_time_event <= t;
      @(posedge mclk);
      cmp_event <= 1'b0;
      charge_time_event <= 1'b0;
      @(posedge mclk);
      seen = timer_clr;
      repeat (4) @(posedge mclk);
      bus(1'b0, A_CTRL0, 32'h0);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      mismatches++;
      $display("[ERR] watchdog exp=done got=timeout");
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      for (int a = 0; a < 32; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         `CHK("reset read", 32'h0, rd)
      end
      for (int p = 0; p < 16; p++) begin
         bus(1'b1, A_CTRL1, 32'(p));
         bus(1'b0, A_PORT, 32'h0);
         `CHK("port", {20'h0, port_pin & ((p < 4) ? 12'h0 : 12'(12'hfff << (15 - p)))}, rd)
      end
      $display("test registers done");
      // start in the enabling write must not start
      bus(1'b1, A_CTRL0, 32'h3);
      bus(1'b0, A_CTRL0, 32'h0);
      `CHK("go with enable", 32'h1, rd)
      bus(1'b1, A_CTRL2, 32'h80);
      convert(8'h3f);
      `CHK("channel", 4'hf, afe.channel)
      bus(1'b0, A_CTRL0, 32'h0);
      `CHK("go cleared", 32'h3d, rd)
      chk_res(8'h02, 8'ha5);
      bus(1'b1, A_CTRL2, 32'h00);
      chk_res(8'ha9, 8'h40);
      $display("test result format done");
      for (int k = 1; k < 8; k++) begin
         bus(1'b1, A_CTRL2, 32'(k << 3));
         convert(8'h03);
         if (k == 1) base = cyc;
         `CHK("acq span", 2 * (acq_p[k] - 2), cyc - base)
      end
      bus(1'b1, A_CTRL2, 32'h0);
      convert(8'h03);
      base = cyc;
      `CHK("delayed start", 1'b1, cyc >= 26 && cyc <= 31)
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, A_CTRL2, 32'(csel[i]));
         convert(8'h03);
         `CHK("clock span", 11 * (dv[i] - 2), cyc - base)
      end
      for (int j = 3; j < 8; j += 4) begin
         bus(1'b1, A_CTRL2, 32'(j));
         convert(8'h03);
         `CHK("rc span", 1'b1, cyc > 100)
      end
      $display("test timing done");
      ain <= 10'h155;
      bus(1'b1, A_CTRL2, 32'h86);
      bus(1'b1, A_CTRL0, 32'h3);
      repeat (300) @(posedge mclk);
      bus(1'b1, A_CTRL0, 32'h1);
      cyc = 0;
      while (afe.sample_en !== 1'b1) begin
         @(posedge mclk);
         cyc++;
      end
      `CHK("abort wait", 1'b1, cyc >= 128 && cyc < 140)
      chk_res(8'h02, 8'ha5);
      bus(1'b0, A_FLAG, 32'h0);
      `CHK("abort flag", 32'h0, rd)
      $display("test abort done");
      ain <= 10'h100;
      bus(1'b1, A_CTRL2, 32'h80);
      convert(8'h83);
      bus(1'b0, A_CTRL0, 32'h0);
      `CHK("cal request", 32'h1, rd)
      chk_res(8'h02, 8'ha5);
      convert(8'h03);
      chk_res(8'h00, 8'hfb);
      $display("test calibration done");
      bus(1'b1, A_CTRL2, 32'h86);
      for (int i = 0; i < 5; i++) begin
         compare_mode_sel <= (i == 1) ? 4'ha : CMP_TRIG_MODE;
         bus(1'b1, A_CTRL1, 32'({5'b01100 >> i, 7'h0}) & 32'h80);
         bus(1'b1, A_CTRL0, 32'(5'b01111 >> i) & 32'h1);
         trig(1'((5'b10111 >> i) & 5'h1), 1'((5'b01000 >> i) & 5'h1));
         `CHK("timer clear", 1'((5'b10101 >> i) & 5'h1), seen)
         `CHK("trigger start", 32'((5'b01001 >> i) & 5'h1) * 2 + 32'((5'b01111 >> i) & 5'h1), rd)
         if (((5'b01001 >> i) & 5'h1) != 0) finish();
      end
      $display("test triggers done");
      print_verdict();
   end
endmodule
